// file: design/pdl_pkg.sv
// What this block does
// - Program memory is written only by the power-on download, nothing else.
// - Select is driven low during download and held high once it finishes.
// - Port F pins 1..3 serve the EEPROM during download, then general I/O.
// - Opcode, address and data go MSB first; transfer opens with select falling.
// - The download port has no path from running firmware.
// - Select asserted and a 3 MHz serial clock runs until the read completes.
// - Read opcode 00000011 is sent, then a 16-bit start address of zero.
// - Only two address bytes are sent; no third byte is ever generated.
// - After 24K bytes the serial clock stops and select is released.
// - Program memory is 12K x 16; bytes pack into words; 14-bit fetch address.
// - Working registers answer the lowest 32 data-space addresses.
// - The 64 I/O locations are reached directly or just above the registers.
// - First 96 addresses are registers and I/O, next 1024 are SRAM.
// - Addresses 1F00 to 1FFF go to the USB register window.
// - Registers 26..31 form three 16-bit pointers, low byte then high byte.
// - Displacement mode adds up to 63 to the two upper pointers.
// - Pre-decrement and post-increment modes update the pointer and write it back.
// - The 10-bit stack pointer is readable and writable in I/O space.
package pdl_pkg;

  localparam int LINK_CLK_PERIOD_NS = 80;
  localparam int SCK_FREQ_KHZ = 3000;
  localparam int SCK_PERIOD_NS = 1000000 / SCK_FREQ_KHZ;
  localparam int SCK_HALF_CYC_RAW = SCK_PERIOD_NS / 2 / LINK_CLK_PERIOD_NS;
  localparam int SCK_HALF_CYC = (SCK_HALF_CYC_RAW < 1) ? 1 : SCK_HALF_CYC_RAW;
  localparam int DIV_W = 4;

  localparam logic [7:0] OPCODE_READ = 8'h03;
  localparam logic [15:0] START_ADDR = 16'h0000;
  localparam int HDR_BITS = 24;
  localparam int IMAGE_BYTES = 24576;
  localparam int PM_WORDS = IMAGE_BYTES / 2;
  localparam int PM_AW = 14;

  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] SRAM_BASE = 16'h0060;
  localparam logic [15:0] SRAM_END = 16'h045f;
  localparam logic [15:0] USB_BASE = 16'h1f00;
  localparam logic [15:0] USB_END = 16'h1fff;
  localparam int SRAM_BYTES = 1024;
  localparam int SRAM_AW = 10;
  localparam int SP_W = 10;
  localparam logic [5:0] SP_LO_IO = 6'h3d;
  localparam logic [5:0] SP_HI_IO = 6'h3e;
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;

  typedef enum logic [2:0] {AM_DIRECT, AM_IO, AM_IND, AM_DISP, AM_PREDEC, AM_POSTINC} pdl_mode_t;
  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} pdl_ptr_t;
  typedef enum logic [2:0] {RG_REG, RG_IO, RG_SRAM, RG_USB, RG_NONE} pdl_region_t;
  typedef enum logic [2:0] {LK_IDLE, LK_SEND, LK_RECV, LK_FINISH, LK_DONE} pdl_lk_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    pdl_mode_t mode;
    pdl_ptr_t ptr;
    logic [5:0] disp;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pdl_dreq_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } pdl_drsp_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic usb;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pdl_periph_t;

endpackage

// file: design/pdl_mem.sv
`timescale 1ns/1ps
module pdl_mem #(
  parameter int DW = 16,
  parameter int DEPTH = 12288,
  parameter int AW = 14
) (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_ff
);

  logic [DW-1:0] mem [DEPTH];

  if (DEPTH < 2 || DEPTH > (1 << AW)) begin
    $error("pdl_mem: depth does not fit the address width.");
  end

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_ff <= mem[raddr];
  end

endmodule

// file: design/pdl_loader_top.sv
`timescale 1ns/1ps
module pdl_loader_top #(
  parameter int IMAGE_WORDS = 12288
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_eeprom,
  output logic eeprom_select_n,
  input wire logic [3:1] port_f_in,
  output logic [3:1] port_f_out,
  output logic [3:1] port_f_oe_n,
  input wire logic [3:1] gpio_drive,
  input wire logic [3:1] gpio_dir,
  output logic [3:1] gpio_in,
  output logic cpu_reset,
  input wire logic [pdl_pkg::PM_AW-1:0] pm_fetch_addr,
  output logic [15:0] pm_fetch_data,
  input wire pdl_pkg::pdl_dreq_t dreq,
  output pdl_pkg::pdl_drsp_t drsp,
  output pdl_pkg::pdl_periph_t periph,
  input wire logic [7:0] periph_rdata
);
  import pdl_pkg::*;

  if (IMAGE_WORDS < 1 || IMAGE_WORDS > PM_WORDS) begin
    $error("pdl_loader_top: image word count out of range.");
  end
  if (SCK_HALF_CYC < 2 || SCK_HALF_CYC >= (1 << DIV_W)) begin
    $error("pdl_loader_top: serial clock half period unusable.");
  end

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);
  localparam logic [4:0] HDR_LAST = 5'(HDR_BITS - 1);
  localparam logic [PM_AW-1:0] WORD_LAST = PM_AW'(IMAGE_WORDS - 1);
  localparam logic [PM_AW:0] WORD_TOTAL = (PM_AW + 1)'(IMAGE_WORDS);

  // Link-side state, clocked by clk_eeprom.
  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    pdl_lk_state_t st;
    logic [DIV_W-1:0] div;
    logic sel_n;
    logic [3:1] pf_out;
    logic [3:1] pf_oe_n;
    logic [HDR_BITS-1:0] hdr;
    logic [4:0] hdr_cnt;
    logic [7:0] shreg;
    logic [2:0] bit_cnt;
    logic hi_phase;
    logic [7:0] lo_byte;
    logic [15:0] word;
    logic tog;
    logic [PM_AW-1:0] word_cnt;
    logic done;
    logic miso_meta;
    logic miso_sync;
    logic [3:1] gpo_meta;
    logic [3:1] gpo_sync;
    logic [3:1] gpoe_meta;
    logic [3:1] gpoe_sync;
  } pdl_lk_st_t;

  // Processor-side state, clocked by clk_sys.
  typedef struct packed {
    logic [31:0][7:0] rf;
    logic [SP_W-1:0] sp;
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic done_meta;
    logic done_sync;
    logic [PM_AW:0] wr_cnt;
    logic cpu_reset;
    logic s1_valid;
    logic s1_write;
    pdl_region_t s1_region;
    logic [15:0] s1_addr;
    pdl_periph_t periph;
    pdl_drsp_t rsp;
    logic [3:1] gpin_meta;
    logic [3:1] gpin_sync;
    logic [3:1] gpo;
    logic [3:1] gpoe_n;
  } pdl_sys_st_t;

  pdl_lk_st_t lk_ff;
  pdl_lk_st_t nxt_lk;
  pdl_sys_st_t sys_ff;
  pdl_sys_st_t nxt_sys;

  logic pm_we;
  logic sram_we;
  logic [SRAM_AW-1:0] sram_addr;
  logic [7:0] sram_rdata;
  logic [15:0] ea;
  logic [15:0] pval;
  logic [4:0] pidx;
  pdl_region_t region;
  logic take;
  logic [5:0] io_idx;
  logic [5:0] s1_io_idx;

  // Link side. Nothing from the processor side steers it except the GPIO
  // levels, and those are used only after the download has ended.
  always_comb begin
    nxt_lk = lk_ff;
    nxt_lk.rst_meta = reset;
    nxt_lk.rst_sync = lk_ff.rst_meta;
    nxt_lk.miso_meta = port_f_in[3];
    nxt_lk.miso_sync = lk_ff.miso_meta;
    nxt_lk.gpo_meta = sys_ff.gpo;
    nxt_lk.gpo_sync = lk_ff.gpo_meta;
    nxt_lk.gpoe_meta = sys_ff.gpoe_n;
    nxt_lk.gpoe_sync = lk_ff.gpoe_meta;
    if (lk_ff.rst_sync) begin
      nxt_lk.st = LK_IDLE;
      nxt_lk.div = '0;
      nxt_lk.sel_n = 1'b1;
      nxt_lk.pf_out = '0;
      nxt_lk.pf_oe_n = '1;
      nxt_lk.hdr = '0;
      nxt_lk.hdr_cnt = '0;
      nxt_lk.shreg = '0;
      nxt_lk.bit_cnt = '0;
      nxt_lk.hi_phase = 1'b0;
      nxt_lk.lo_byte = '0;
      nxt_lk.word = '0;
      nxt_lk.tog = 1'b0;
      nxt_lk.word_cnt = '0;
      nxt_lk.done = 1'b0;
    end else begin
      unique case (lk_ff.st)
        LK_IDLE: begin
          // Select falls with the first header bit already on the data line.
          nxt_lk.sel_n = 1'b0;
          nxt_lk.pf_oe_n = 3'b100;
          nxt_lk.pf_out = {1'b0, OPCODE_READ[7], 1'b0};
          nxt_lk.hdr = {OPCODE_READ, START_ADDR};
          nxt_lk.hdr_cnt = '0;
          nxt_lk.div = '0;
          nxt_lk.st = LK_SEND;
        end
        LK_SEND, LK_RECV: begin
          // The serial clock runs without a gap from the first header bit
          // to the last data bit.
          if (lk_ff.div == DIV_LAST) begin
            nxt_lk.div = '0;
            if (!lk_ff.pf_out[1]) begin
              nxt_lk.pf_out[1] = 1'b1;
            end else begin
              nxt_lk.pf_out[1] = 1'b0;
              if (lk_ff.st == LK_SEND) begin
                nxt_lk.hdr = {lk_ff.hdr[HDR_BITS-2:0], 1'b0};
                nxt_lk.pf_out[2] = lk_ff.hdr[HDR_BITS-2];
                nxt_lk.hdr_cnt = lk_ff.hdr_cnt + 5'h01;
                if (lk_ff.hdr_cnt == HDR_LAST) begin
                  nxt_lk.pf_out[2] = 1'b0;
                  nxt_lk.bit_cnt = '0;
                  nxt_lk.st = LK_RECV;
                end
              end else begin
                // The synchronised data bit sampled here left the pin two
                // link cycles ago, at the rising edge, so it is stable.
                nxt_lk.shreg = {lk_ff.shreg[6:0], lk_ff.miso_sync};
                nxt_lk.bit_cnt = lk_ff.bit_cnt + 3'h1;
                if (lk_ff.bit_cnt == 3'h7) begin
                  if (!lk_ff.hi_phase) begin
                    nxt_lk.lo_byte = {lk_ff.shreg[6:0], lk_ff.miso_sync};
                    nxt_lk.hi_phase = 1'b1;
                  end else begin
                    nxt_lk.word = {lk_ff.shreg[6:0], lk_ff.miso_sync, lk_ff.lo_byte};
                    nxt_lk.tog = ~lk_ff.tog;
                    nxt_lk.hi_phase = 1'b0;
                    nxt_lk.word_cnt = lk_ff.word_cnt + PM_AW'(1);
                    if (lk_ff.word_cnt == WORD_LAST) begin
                      nxt_lk.st = LK_FINISH;
                    end
                  end
                end
              end
            end
          end else begin
            nxt_lk.div = lk_ff.div + DIV_W'(1);
          end
        end
        LK_FINISH: begin
          nxt_lk.sel_n = 1'b1;
          nxt_lk.pf_out = lk_ff.gpo_sync;
          nxt_lk.pf_oe_n = lk_ff.gpoe_sync;
          nxt_lk.st = LK_DONE;
        end
        LK_DONE: begin
          nxt_lk.pf_out = lk_ff.gpo_sync;
          nxt_lk.pf_oe_n = lk_ff.gpoe_sync;
          nxt_lk.done = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_eeprom) begin
    lk_ff <= nxt_lk;
  end

  // Effective address of a data access, computed in the request cycle so
  // that the SRAM read is issued at once.
  always_comb begin
    unique case (dreq.ptr)
      PTR_Y: pidx = PTR_Y_LO;
      PTR_Z: pidx = PTR_Z_LO;
      default: pidx = PTR_X_LO;
    endcase
    pval = {sys_ff.rf[pidx + 5'h01], sys_ff.rf[pidx]};
    unique case (dreq.mode)
      AM_DIRECT: ea = dreq.addr;
      AM_IO: ea = IO_BASE + {10'h000, dreq.addr[5:0]};
      AM_IND, AM_POSTINC: ea = pval;
      // The lowest pointer has no displacement form, so it reads plain.
      AM_DISP: ea = (dreq.ptr == PTR_X) ? pval : pval + {10'h000, dreq.disp};
      AM_PREDEC: ea = pval - 16'h0001;
      default: ea = dreq.addr;
    endcase
    if (ea < IO_BASE) begin
      region = RG_REG;
    end else if (ea < SRAM_BASE) begin
      region = RG_IO;
    end else if (ea <= SRAM_END) begin
      region = RG_SRAM;
    end else if (ea >= USB_BASE && ea <= USB_END) begin
      region = RG_USB;
    end else begin
      region = RG_NONE;
    end
    io_idx = 6'(ea - IO_BASE);
    s1_io_idx = 6'(sys_ff.s1_addr - IO_BASE);
    sram_addr = SRAM_AW'(ea - SRAM_BASE);
    take = dreq.valid && !sys_ff.cpu_reset;
    sram_we = take && dreq.write && region == RG_SRAM;
    // Only the download writes program memory, and only until it is whole.
    pm_we = (sys_ff.tog_sync != sys_ff.tog_seen) && sys_ff.wr_cnt < WORD_TOTAL;
  end

  always_comb begin
    nxt_sys = sys_ff;
    nxt_sys.tog_meta = lk_ff.tog;
    nxt_sys.tog_sync = sys_ff.tog_meta;
    nxt_sys.tog_seen = sys_ff.tog_sync;
    nxt_sys.done_meta = lk_ff.done;
    nxt_sys.done_sync = sys_ff.done_meta;
    nxt_sys.gpin_meta = port_f_in;
    nxt_sys.gpin_sync = sys_ff.gpin_meta;
    nxt_sys.gpo = gpio_drive;
    nxt_sys.gpoe_n = ~gpio_dir;
    if (pm_we) begin
      nxt_sys.wr_cnt = sys_ff.wr_cnt + (PM_AW + 1)'(1);
    end
    // The word counter guards against a done level that overtakes the last
    // word on its way across.
    nxt_sys.cpu_reset = !(sys_ff.done_sync && sys_ff.wr_cnt == WORD_TOTAL);
    nxt_sys.s1_valid = take;
    nxt_sys.s1_write = dreq.write;
    nxt_sys.s1_region = region;
    nxt_sys.s1_addr = ea;
    nxt_sys.periph = '0;
    if (take) begin
      if (dreq.write && region == RG_REG) begin
        nxt_sys.rf[ea[4:0]] = dreq.wdata;
      end
      if (dreq.write && region == RG_IO && io_idx == SP_LO_IO) begin
        nxt_sys.sp[7:0] = dreq.wdata;
      end
      if (dreq.write && region == RG_IO && io_idx == SP_HI_IO) begin
        nxt_sys.sp[SP_W-1:8] = dreq.wdata[SP_W-9:0];
      end
      if ((region == RG_IO && io_idx != SP_LO_IO && io_idx != SP_HI_IO) ||
          region == RG_USB) begin
        nxt_sys.periph.valid = 1'b1;
        nxt_sys.periph.write = dreq.write;
        nxt_sys.periph.usb = (region == RG_USB);
        nxt_sys.periph.addr = (region == RG_USB) ? ea[7:0] : {2'b00, io_idx};
        nxt_sys.periph.wdata = dreq.wdata;
      end
      // The pointer update lands after a data write to the same register.
      if (dreq.mode == AM_PREDEC) begin
        {nxt_sys.rf[pidx + 5'h01], nxt_sys.rf[pidx]} = pval - 16'h0001;
      end else if (dreq.mode == AM_POSTINC) begin
        {nxt_sys.rf[pidx + 5'h01], nxt_sys.rf[pidx]} = pval + 16'h0001;
      end
    end
    nxt_sys.rsp.valid = sys_ff.s1_valid;
    nxt_sys.rsp.rdata = '0;
    if (sys_ff.s1_valid && !sys_ff.s1_write) begin
      unique case (sys_ff.s1_region)
        RG_REG: nxt_sys.rsp.rdata = sys_ff.rf[sys_ff.s1_addr[4:0]];
        RG_IO: begin
          if (s1_io_idx == SP_LO_IO) begin
            nxt_sys.rsp.rdata = sys_ff.sp[7:0];
          end else if (s1_io_idx == SP_HI_IO) begin
            nxt_sys.rsp.rdata = {{(16 - SP_W){1'b0}}, sys_ff.sp[SP_W-1:8]};
          end else begin
            nxt_sys.rsp.rdata = periph_rdata;
          end
        end
        RG_SRAM: nxt_sys.rsp.rdata = sram_rdata;
        RG_USB: nxt_sys.rsp.rdata = periph_rdata;
        RG_NONE: nxt_sys.rsp.rdata = '0;
      endcase
    end
    if (reset) begin
      nxt_sys.rf = '0;
      nxt_sys.sp = '0;
      nxt_sys.tog_seen = 1'b0;
      nxt_sys.tog_sync = 1'b0;
      nxt_sys.tog_meta = 1'b0;
      nxt_sys.done_meta = 1'b0;
      nxt_sys.done_sync = 1'b0;
      nxt_sys.wr_cnt = '0;
      nxt_sys.cpu_reset = 1'b1;
      nxt_sys.s1_valid = 1'b0;
      nxt_sys.s1_write = 1'b0;
      nxt_sys.s1_region = RG_NONE;
      nxt_sys.s1_addr = '0;
      nxt_sys.periph = '0;
      nxt_sys.rsp = '0;
      nxt_sys.gpo = '0;
      nxt_sys.gpoe_n = '1;
    end
  end

  always_ff @(posedge clk_sys) begin
    sys_ff <= nxt_sys;
  end

  // The link word is held for a whole word time after its toggle, far
  // longer than the three processor cycles needed to see the toggle.
  pdl_mem #(
    .DW(16),
    .DEPTH(PM_WORDS),
    .AW(PM_AW)
  ) u_pm (
    .clk_sys(clk_sys),
    .we(pm_we),
    .waddr(sys_ff.wr_cnt[PM_AW-1:0]),
    .wdata(lk_ff.word),
    .raddr(pm_fetch_addr),
    .rdata_ff(pm_fetch_data)
  );

  pdl_mem #(
    .DW(8),
    .DEPTH(SRAM_BYTES),
    .AW(SRAM_AW)
  ) u_sram (
    .clk_sys(clk_sys),
    .we(sram_we),
    .waddr(sram_addr),
    .wdata(dreq.wdata),
    .raddr(sram_addr),
    .rdata_ff(sram_rdata)
  );

  assign eeprom_select_n = lk_ff.sel_n;
  assign port_f_out = lk_ff.pf_out;
  assign port_f_oe_n = lk_ff.pf_oe_n;
  assign gpio_in = sys_ff.gpin_sync;
  assign cpu_reset = sys_ff.cpu_reset;
  assign drsp = sys_ff.rsp;
  assign periph = sys_ff.periph;

endmodule

// file: test/pdl_loader_props.sv
`timescale 1ns/1ps
module pdl_loader_props
  import pdl_pkg::*;
#(
  parameter int IMAGE_WORDS = 12288
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_eeprom,
  input wire logic eeprom_select_n,
  input wire logic [3:1] port_f_out,
  input wire logic [3:1] port_f_oe_n,
  input wire logic cpu_reset,
  input wire pdl_pkg::pdl_dreq_t dreq,
  input wire pdl_pkg::pdl_drsp_t drsp,
  input wire pdl_pkg::pdl_periph_t periph
);
  import pdl_pkg::*;
  logic taken;
  assign taken = dreq.valid && !cpu_reset;
  hold_cpu_a: assert property (@(posedge clk_sys) disable iff (reset)
    !eeprom_select_n |-> cpu_reset) else $error("cpu released during download");
  rsp_time_a: assert property (@(posedge clk_sys) disable iff (reset)
    taken |-> ##2 drsp.valid) else $error("response not two cycles after request");
  rsp_cause_a: assert property (@(posedge clk_sys) disable iff (reset)
    drsp.valid |-> $past(dreq.valid, 2)) else $error("response without request");
  io_fwd_a: assert property (@(posedge clk_sys) disable iff (reset)
    taken && dreq.mode == AM_IO && dreq.addr[5:0] < SP_LO_IO |=> periph.valid && !periph.usb
    && periph.addr == {2'b00, $past(dreq.addr[5:0])}) else $error("io access not forwarded");
  usb_fwd_a: assert property (@(posedge clk_sys) disable iff (reset)
    taken && dreq.mode == AM_DIRECT && dreq.addr[15:8] == 8'h1f |=> periph.valid
    && periph.usb && periph.addr == $past(dreq.addr[7:0])) else $error("usb window missed");
  sram_local_a: assert property (@(posedge clk_sys) disable iff (reset)
    taken && dreq.mode == AM_DIRECT && dreq.addr inside {[SRAM_BASE:SRAM_END]}
    |=> !periph.valid) else $error("sram access leaked to peripheral");
  gap_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
    taken && !dreq.write && dreq.mode == AM_DIRECT && dreq.addr inside {[16'h0460:16'h1eff]}
    |-> ##2 drsp.rdata == 8'h00) else $error("unmapped read not zero");
  pin_take_a: assert property (@(posedge clk_eeprom) disable iff (reset)
    $fell(eeprom_select_n) |-> port_f_oe_n == 3'b100) else $error("pins not taken for link");
  sck_high_a: assert property (@(posedge clk_eeprom) disable iff (reset)
    !eeprom_select_n && $rose(port_f_out[1]) |=> port_f_out[1] ##1 !port_f_out[1])
    else $error("serial clock high phase wrong");
  mosi_low_a: assert property (@(posedge clk_eeprom) disable iff (reset)
    !eeprom_select_n && !$past(eeprom_select_n) && $changed(port_f_out[2]) |-> !port_f_out[1])
    else $error("data out moved while clock high");
endmodule
bind pdl_loader_top pdl_loader_props #(.IMAGE_WORDS(IMAGE_WORDS)) pdl_loader_props_i (
  .clk_sys(clk_sys), .reset(reset), .clk_eeprom(clk_eeprom),
  .eeprom_select_n(eeprom_select_n), .port_f_out(port_f_out), .port_f_oe_n(port_f_oe_n),
  .cpu_reset(cpu_reset), .dreq(dreq), .drsp(drsp), .periph(periph));

// file: test/pdl_eeprom_model.sv
`timescale 1ns/1ps
module pdl_eeprom_model (
  input wire logic select_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic [23:0] hdr,
  output int n_rise
);
  logic drv;
  logic [7:0] b;
  int k;
  initial begin
    drv = 1'b0;
    hdr = '0;
    n_rise = 0;
  end
  always @(negedge select_n) begin
    hdr = '0;
    n_rise = 0;
  end
  always @(posedge sck) if (!select_n) begin
    if (n_rise < 24) hdr = {hdr[22:0], mosi};
    n_rise = n_rise + 1;
  end
  // Outside the data phase the line wanders so a premature sample never looks valid.
  always @(negedge sck) if (!select_n) begin
    k = n_rise - 24;
    b = 8'((k / 8) * 29 + 7);
    if (k >= 0) drv = b[7 - k % 8];
    else drv = ~drv;
  end
  assign miso = select_n ? ~drv : drv;
endmodule

// file: test/pdl_loader_top_tb.sv
`timescale 1ns/1ps
module pdl_loader_top_tb;
  import pdl_pkg::*;
  localparam int NW = 4;
  logic clk_sys = 1'b0;
  logic clk_eeprom = 1'b0;
  logic reset = 1'b1;
  logic eeprom_select_n, cpu_reset, miso;
  logic [3:1] pin, port_f_out, port_f_oe_n, gpio_in;
  logic [3:1] gpio_drive = 3'h0;
  logic [3:1] gpio_dir = 3'h0;
  logic [3:1] pin_ext = 3'h5;
  logic [13:0] pm_fetch_addr = 14'h0000;
  logic [15:0] pm_fetch_data;
  logic [7:0] rd;
  logic [23:0] hdr;
  int n_rise;
  int n_mismatch = 0;
  int checked = 0;
  pdl_dreq_t dreq = '0;
  pdl_drsp_t drsp;
  pdl_periph_t periph, pp;
  assign pin[1] = port_f_oe_n[1] ? pin_ext[1] : port_f_out[1];
  assign pin[2] = port_f_oe_n[2] ? pin_ext[2] : port_f_out[2];
  assign pin[3] = !port_f_oe_n[3] ? port_f_out[3] : (eeprom_select_n ? pin_ext[3] : miso);
  always #50 clk_sys = ~clk_sys;
  initial begin
    #17;
    forever #40 clk_eeprom = ~clk_eeprom;
  end
  pdl_loader_top #(.IMAGE_WORDS(NW)) pdl_loader_top_i (.clk_sys(clk_sys), .reset(reset),
    .clk_eeprom(clk_eeprom), .eeprom_select_n(eeprom_select_n), .port_f_in(pin),
    .port_f_out(port_f_out), .port_f_oe_n(port_f_oe_n), .gpio_drive(gpio_drive),
    .gpio_dir(gpio_dir), .gpio_in(gpio_in), .cpu_reset(cpu_reset),
    .pm_fetch_addr(pm_fetch_addr), .pm_fetch_data(pm_fetch_data), .dreq(dreq), .drsp(drsp),
    .periph(periph), .periph_rdata(8'hc3));
  pdl_eeprom_model pdl_eeprom_model_i (.select_n(eeprom_select_n), .sck(pin[1]),
    .mosi(pin[2]), .miso(miso), .hdr(hdr), .n_rise(n_rise));
  task automatic final_report;
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic wr, input pdl_mode_t md, input pdl_ptr_t pt,
                     input logic [5:0] ds, input logic [15:0] ad, input logic [7:0] wd);
    dreq = '{1'b1, wr, md, pt, ds, ad, wd};
    // The peripheral strobe stands in the cycle after the request, the response one later.
    @(negedge clk_sys) dreq.valid = 1'b0;
    pp = periph;
    @(negedge clk_sys) rd = drsp.rdata;
    check(drsp.valid, 1'b1);
  endtask
  task automatic t_download;
    int n;
    dreq = '{1'b1, 1'b1, AM_DIRECT, PTR_X, 6'h00, 16'h0070, 8'hee};
    @(negedge clk_sys) dreq.valid = 1'b0;
    @(negedge clk_sys);
    check(drsp.valid, 1'b0);
    n = 0;
    while (cpu_reset !== 1'b0 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 5000) begin
      check(1'b1, 1'b0);
      final_report;
    end
    check(hdr, 24'h030000);
    check(n_rise, 24 + NW * 16);
    check(port_f_oe_n, 3'h7);
    check(eeprom_select_n, 1'b1);
    repeat (20) @(negedge clk_sys);
    check(n_rise, 24 + NW * 16);
    for (int j = 0; j < NW; j++) begin
      pm_fetch_addr = 14'(j);
      @(negedge clk_sys);
      check(pm_fetch_data, {8'((2 * j + 1) * 29 + 7), 8'((2 * j) * 29 + 7)});
    end
  endtask
  task automatic t_map;
    acc(1'b1, AM_DIRECT, PTR_X, 6'h00, 16'h0005, 8'h3c);
    acc(0, AM_DIRECT, PTR_X, 6'h00, 16'h0005, 8'h00);
    check(rd, 8'h3c);
    acc(1'b1, AM_DIRECT, PTR_X, 6'h00, 16'h0060, 8'ha5);
    acc(1'b1, AM_DIRECT, PTR_X, 6'h00, 16'h045f, 8'h96);
    acc(1'b1, AM_DIRECT, PTR_X, 6'h00, 16'h0460, 8'h11);
    acc(0, AM_DIRECT, PTR_X, 6'h00, 16'h0060, 8'h00);
    check(rd, 8'ha5);
    acc(0, AM_DIRECT, PTR_X, 6'h00, 16'h045f, 8'h00);
    check(rd, 8'h96);
    acc(0, AM_DIRECT, PTR_X, 6'h00, 16'h0460, 8'h00);
    check(rd, 8'h00);
    acc(0, AM_DIRECT, PTR_X, 6'h00, 16'h0025, 8'h00);
    check({pp.valid, pp.usb, pp.addr, rd}, {2'b10, 8'h05, 8'hc3});
    acc(0, AM_IO, PTR_X, 6'h00, 16'h0007, 8'h00);
    check({pp.valid, pp.usb, pp.addr}, {2'b10, 8'h07});
    acc(1'b1, AM_DIRECT, PTR_X, 6'h00, 16'h1f80, 8'h5e);
    check({pp.valid, pp.usb, pp.write, pp.addr, pp.wdata}, {3'b111, 16'h805e});
    acc(0, AM_DIRECT, PTR_X, 6'h00, 16'h1eff, 8'h00);
    check({pp.valid, rd}, 9'h000);
  endtask
  task automatic t_ptr;
    acc(1'b1, AM_DIRECT, PTR_X, 6'h00, 16'h001a, 8'h61);
    acc(1'b1, AM_DIRECT, PTR_X, 6'h00, 16'h001b, 8'h00);
    acc(1'b1, AM_POSTINC, PTR_X, 6'h00, 16'h0000, 8'h77);
    acc(0, AM_DIRECT, PTR_X, 6'h00, 16'h001a, 8'h00);
    check(rd, 8'h62);
    acc(0, AM_PREDEC, PTR_X, 6'h00, 16'h0000, 8'h00);
    check(rd, 8'h77);
    acc(1'b1, AM_DIRECT, PTR_X, 6'h00, 16'h001c, 8'h60);
    acc(1'b1, AM_DIRECT, PTR_X, 6'h00, 16'h001d, 8'h00);
    acc(1'b1, AM_DISP, PTR_Y, 6'h3f, 16'h0000, 8'h4b);
    acc(0, AM_DIRECT, PTR_X, 6'h00, 16'h009f, 8'h00);
    check(rd, 8'h4b);
    acc(0, AM_DISP, PTR_X, 6'h3f, 16'h0000, 8'h00);
    check(rd, 8'h77);
    acc(1'b1, AM_DIRECT, PTR_X, 6'h00, 16'h001e, 8'h9f);
    acc(1'b1, AM_DIRECT, PTR_X, 6'h00, 16'h001f, 8'h00);
    acc(0, AM_IND, PTR_Z, 6'h00, 16'h0000, 8'h00);
    check(rd, 8'h4b);
    acc(1'b1, AM_IO, PTR_X, 6'h00, 16'h003e, 8'hff);
    acc(0, AM_IO, PTR_X, 6'h00, 16'h003e, 8'h00);
    check({pp.valid, rd}, 9'h003);
  endtask
  task automatic t_gpio;
    int n;
    gpio_dir = 3'b110;
    gpio_drive = 3'b010;
    pin_ext = 3'b101;
    n = 0;
    while ((port_f_oe_n !== 3'b001 || gpio_in[1] !== 1'b1) && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    check({port_f_oe_n, port_f_out[3:2], gpio_in[1]}, 6'b001011);
    check(eeprom_select_n, 1'b1);
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    t_download;
    t_map;
    t_ptr;
    t_gpio;
    final_report;
  end
endmodule
